// ==== rtl/bstap_pkg.sv ====
// Package for the boundary-scan test access port controller.
// Assumes a single system clock that oversamples the test clock pin.
package bstap_pkg;

	typedef enum {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} bstap_state_t;

	localparam int IR_W    = 8;
	localparam int BSR_W   = 48;
	localparam int BCR_W   = 3;
	localparam int IDR_W   = 32;

	// Instruction pattern loaded at reset and captured in Capture-IR
	localparam logic [7:0] IR_RESET_VAL  = 8'h81;
	localparam logic [7:0] IR_CAPTURE_VAL = 8'h81;
	// Signature analysis operation code
	localparam logic [2:0] BCR_RESET_VAL = 3'h2;
	localparam logic [2:0] SIGNATURE_ANALYSIS_OP = 3'h2;
	localparam int BSR_OE_LO = 44;
	localparam logic [3:0] BSR_OE_RESET = 4'hf;
	localparam logic       BYP_CAPTURE_VAL = 1'h0;

	// Instruction opcodes used for path selection (arbitrary encodings)
	localparam logic [7:0] OP_BYPASS  = 8'hff;
	localparam logic [7:0] OP_IDCODE  = 8'h81;
	localparam logic [7:0] OP_SAMPLE  = 8'h82;
	localparam logic [7:0] OP_EXTEST  = 8'h00;
	localparam logic [7:0] OP_BCR     = 8'h87;

	// Identification value, arbitrary
	localparam logic [31:0] IDCODE_VAL = 32'h00000001;

	typedef enum {SEL_BYP, SEL_IDR, SEL_BSR, SEL_BCR} bstap_sel_t;

endpackage

// ==== rtl/bstap_fifo.sv ====
// Small synchronous FIFO carrying captured scan-out bits to the user side.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module bstap_fifo #(
	parameter int W = 1,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          wr;
	logic          rd;

	assign in_ready_o  = (cnt_q != (AW+1)'(D));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem[rp_q];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem[wp_q] <= in_data_i;
		end
		if (!resetn_i) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

// ==== rtl/bstap_ctrl.sv ====
// Boundary-scan test access port controller: state machine, instruction
// register and four data registers, with the test clock oversampled by clk_i.
// Assumes clk_i is at least four times faster than the test clock.
`timescale 1ns/10ps
module bstap_ctrl (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	// Test pins
	input  wire logic                       tck_i,
	input  wire logic                       tms_i,
	input  wire logic                       tdi_i,
	output logic                            tdo_o,
	output logic                            tdo_oe_n_o,
	// Boundary capture sources and shadow outputs
	input  wire logic [bstap_pkg::BSR_W-1:0] bsr_pins_i,
	output logic      [bstap_pkg::BSR_W-1:0] bsr_shadow_o,
	output logic      [bstap_pkg::BCR_W-1:0] bcr_shadow_o,
	output logic      [bstap_pkg::IR_W-1:0]  ir_current_o,
	// Status
	output logic                            test_logic_reset_o,
	output logic                            run_op_o,
	// Scan-out bit stream
	output logic                            so_valid_o,
	input  wire logic                       so_ready_i,
	output logic                            so_data_o
);
	import bstap_pkg::*;

	typedef struct packed {
		logic [2:0]       tck_s;
		logic [1:0]       tms_s;
		logic [1:0]       tdi_s;
		bstap_state_t     st;
		logic [IR_W-1:0]  ir_sh;
		logic [IR_W-1:0]  ir;
		logic [BSR_W-1:0] bsr_sh;
		logic [BSR_W-1:0] bsr;
		logic [BCR_W-1:0] bcr_sh;
		logic [BCR_W-1:0] bcr;
		logic             byp;
		logic [IDR_W-1:0] idr;
		logic             tdo;
		logic             oe_n;
		logic             so_v;
		logic             so_b;
	} bstap_regs_t;

	bstap_regs_t r_q;
	bstap_regs_t r_d;
	logic        rise;
	logic        fall;
	logic        tms;
	logic        tdi;
	logic        f_in_ready;

	function automatic bstap_sel_t sel_of(input logic [IR_W-1:0] op);
		case (op)
			OP_IDCODE: sel_of = SEL_IDR;
			OP_SAMPLE: sel_of = SEL_BSR;
			OP_EXTEST: sel_of = SEL_BSR;
			OP_BCR:    sel_of = SEL_BCR;
			default:   sel_of = SEL_BYP;
		endcase
	endfunction

	// Standard sixteen-state transition table
	function automatic bstap_state_t next_of(input bstap_state_t s, input logic m);
		case (s)
			ST_RESET:    next_of = m ? ST_RESET : ST_IDLE;
			ST_IDLE:     next_of = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   next_of = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   next_of = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_of = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_of = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_of = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_of = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   next_of = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   next_of = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   next_of = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_of = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_of = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_of = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_of = m ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   next_of = m ? ST_SEL_DR : ST_IDLE;
			default:     next_of = ST_RESET;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Test clock edge detection reads only the synchronised stages
	assign rise = r_q.tck_s[1] && !r_q.tck_s[2];
	assign fall = !r_q.tck_s[1] && r_q.tck_s[2];
	assign tms  = r_q.tms_s[1];
	assign tdi  = r_q.tdi_s[1];

	always_comb begin
		bstap_sel_t sel;
		sel = sel_of(r_q.ir);
		r_d = r_q;
		r_d.tck_s = {r_q.tck_s[1:0], tck_i};
		r_d.tms_s = {r_q.tms_s[0], tms_i};
		r_d.tdi_s = {r_q.tdi_s[0], tdi_i};
		r_d.so_v  = 1'b0;
		if (rise) begin
			r_d.st = next_of(r_q.st, tms);
			case (r_q.st)
				ST_CAP_DR: begin
					case (sel)
						SEL_IDR: r_d.idr = IDCODE_VAL;
						SEL_BSR: r_d.bsr_sh = bsr_pins_i;
						SEL_BCR: r_d.bcr_sh = r_q.bcr_sh;
						default: r_d.byp = BYP_CAPTURE_VAL;
					endcase
				end
				ST_SHIFT_DR: begin
					r_d.so_v = 1'b1;
					case (sel)
						SEL_IDR: begin
							r_d.so_b = r_q.idr[0];
							r_d.idr  = {tdi, r_q.idr[IDR_W-1:1]};
						end
						SEL_BSR: begin
							r_d.so_b   = r_q.bsr_sh[0];
							r_d.bsr_sh = {tdi, r_q.bsr_sh[BSR_W-1:1]};
						end
						SEL_BCR: begin
							r_d.so_b   = r_q.bcr_sh[0];
							r_d.bcr_sh = {tdi, r_q.bcr_sh[BCR_W-1:1]};
						end
						default: begin
							r_d.so_b = r_q.byp;
							r_d.byp  = tdi;
						end
					endcase
				end
				ST_CAP_IR: r_d.ir_sh = IR_CAPTURE_VAL;
				ST_SHIFT_IR: begin
					r_d.so_v  = 1'b1;
					r_d.so_b  = r_q.ir_sh[0];
					r_d.ir_sh = {tdi, r_q.ir_sh[IR_W-1:1]};
				end
				default: ;
			endcase
			if (r_d.st == ST_RESET) begin
				// Loaded on entry, so the values stand as soon as the state is reached
				r_d.ir     = IR_RESET_VAL;
				r_d.bcr    = BCR_RESET_VAL;
				r_d.bcr_sh = BCR_RESET_VAL;
				r_d.bsr[BSR_OE_LO +: 4] = BSR_OE_RESET;
			end
		end
		if (fall) begin
			case (r_q.st)
				ST_SHIFT_DR: begin
					r_d.oe_n = 1'b0;
					case (sel)
						SEL_IDR: r_d.tdo = r_q.idr[0];
						SEL_BSR: r_d.tdo = r_q.bsr_sh[0];
						SEL_BCR: r_d.tdo = r_q.bcr_sh[0];
						default: r_d.tdo = r_q.byp;
					endcase
				end
				ST_SHIFT_IR: begin
					r_d.oe_n = 1'b0;
					r_d.tdo  = r_q.ir_sh[0];
				end
				ST_UPD_DR: begin
					if (sel == SEL_BSR) begin
						r_d.bsr = r_q.bsr_sh;
					end
					if (sel == SEL_BCR) begin
						r_d.bcr = r_q.bcr_sh;
					end
				end
				ST_UPD_IR: r_d.ir = r_q.ir_sh;
				default: r_d.oe_n = 1'b1;
			endcase
		end
		if (!f_in_ready) begin
			r_d.so_v = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			r_q        <= '0;
			r_q.st     <= ST_RESET;
			r_q.ir     <= IR_RESET_VAL;
			r_q.bcr    <= BCR_RESET_VAL;
			r_q.bcr_sh <= BCR_RESET_VAL;
			r_q.bsr    <= {BSR_OE_RESET, {(BSR_W-4){1'b0}}};
			r_q.oe_n   <= 1'b1;
			// Pins idle high; any other value fakes a test clock edge after reset
			r_q.tck_s  <= '1;
			r_q.tms_s  <= '1;
			r_q.tdi_s  <= '1;
		end else begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scan-out bits are buffered; a full buffer drops bits, never stalls the pins
	bstap_fifo #(.W(1), .D(16)) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (r_q.so_v),
		.in_ready_o  (f_in_ready),
		.in_data_i   (r_q.so_b),
		.out_valid_o (so_valid_o),
		.out_ready_i (so_ready_i),
		.out_data_o  (so_data_o)
	);

	assign tdo_o              = r_q.tdo;
	assign tdo_oe_n_o         = r_q.oe_n;
	assign bsr_shadow_o       = r_q.bsr;
	assign bcr_shadow_o       = r_q.bcr;
	assign ir_current_o       = r_q.ir;
	assign test_logic_reset_o = (r_q.st == ST_RESET);
	assign run_op_o           = (r_q.st == ST_IDLE) && (sel_of(r_q.ir) == SEL_BCR);

	////////////////////////////////////////////////////////////////////////////
	a_tms_high_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && tms && r_q.st == ST_SEL_IR) |=> (r_q.st == ST_RESET))
		else $error("tms high did not reach reset");
	a_select_leaves: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && (r_q.st == ST_SEL_DR || r_q.st == ST_SEL_IR)) |=>
		(r_q.st != $past(r_q.st)))
		else $error("select state held");
	a_ir_reset_val: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_RESET) |=> (r_q.ir == IR_RESET_VAL))
		else $error("instruction not reset");
	a_bcr_reset_val: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_RESET) |=> (r_q.bcr == SIGNATURE_ANALYSIS_OP))
		else $error("control register not reset");
	a_capir_pattern: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_CAP_IR) |=> (r_q.ir_sh == IR_CAPTURE_VAL))
		else $error("capture-ir pattern wrong");
	a_tdo_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_SHIFT_DR) |=> (!r_q.oe_n))
		else $error("output not enabled in shift");
	a_tdo_float: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && (r_q.st == ST_EXIT1_DR || r_q.st == ST_EXIT1_IR)) |=> r_q.oe_n)
		else $error("output not floated in exit");
	a_pause_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(r_q.st == ST_PAUSE_IR) |=> ($stable(r_q.ir_sh)))
		else $error("pause lost data");
	a_update_ir: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_UPD_IR) |=> (r_q.ir == $past(r_q.ir_sh)))
		else $error("instruction not updated");
	a_byp_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_CAP_DR && sel_of(r_q.ir) == SEL_BYP) |=> !r_q.byp)
		else $error("bypass did not capture zero");

	////////////////////////////////////////////////////////////////////////////
	// Edge discipline of the oversampled test clock
	a_state_on_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!rise |=> $stable(r_q.st))
		else $error("state moved without rising edge");

	a_tdo_on_fall: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!fall |=> ($stable(r_q.tdo) && $stable(r_q.oe_n)))
		else $error("output moved without falling edge");

	a_shift_on_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!rise |=> ($stable(r_q.ir_sh) && $stable(r_q.bsr_sh)))
		else $error("shift stage moved without rising edge");

	////////////////////////////////////////////////////////////////////////////
	// State diagram
	a_idle_stays: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && !tms && r_q.st == ST_IDLE) |=> (r_q.st == ST_IDLE))
		else $error("idle not held");

	a_reset_stays: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && tms && r_q.st == ST_RESET) |=> (r_q.st == ST_RESET))
		else $error("reset state not held");

	a_sel_dr_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_SEL_DR) |=> (r_q.st == ST_SEL_IR || r_q.st == ST_CAP_DR))
		else $error("data select went astray");

	a_reset_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(r_q.st == ST_RESET) |-> (r_q.oe_n && !run_op_o))
		else $error("test logic active in reset state");

	a_bsr_oe_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && tms && r_q.st == ST_SEL_IR) |=> (r_q.bsr[BSR_OE_LO +: 4] == BSR_OE_RESET))
		else $error("output enable cells not reset");

	a_run_op_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		run_op_o |-> (r_q.st == ST_IDLE))
		else $error("operation outside idle");

	////////////////////////////////////////////////////////////////////////////
	// Data path capture, shift and update
	a_capture_bsr: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_CAP_DR && sel_of(r_q.ir) == SEL_BSR) |=>
		(r_q.bsr_sh == $past(bsr_pins_i)))
		else $error("boundary capture wrong");

	a_capture_idr: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_CAP_DR && sel_of(r_q.ir) == SEL_IDR) |=> (r_q.idr == IDCODE_VAL))
		else $error("identification capture wrong");

	a_bcr_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_CAP_DR && sel_of(r_q.ir) == SEL_BCR) |=> $stable(r_q.bcr_sh))
		else $error("control capture changed contents");

	a_shift_dr_lsb: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_SHIFT_DR && sel_of(r_q.ir) == SEL_BSR) |=>
		(r_q.tdo == $past(r_q.bsr_sh[0])))
		else $error("data output not lsb");

	a_bsr_shift: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_SHIFT_DR && sel_of(r_q.ir) == SEL_BSR) |=>
		(r_q.bsr_sh == {$past(tdi), $past(r_q.bsr_sh[BSR_W-1:1])}))
		else $error("boundary shift wrong");

	a_byp_shift: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_SHIFT_DR && sel_of(r_q.ir) == SEL_BYP) |=> (r_q.byp == $past(tdi)))
		else $error("bypass shift wrong");

	a_pause_dr_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(r_q.st == ST_PAUSE_DR) |=> ($stable(r_q.bsr_sh) && $stable(r_q.byp) &&
		$stable(r_q.idr) && $stable(r_q.bcr_sh)))
		else $error("data pause lost data");

	a_bsr_update: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_UPD_DR && sel_of(r_q.ir) == SEL_BSR) |=>
		(r_q.bsr == $past(r_q.bsr_sh)))
		else $error("boundary shadow not updated");

	a_bcr_update: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_UPD_DR && sel_of(r_q.ir) == SEL_BCR) |=>
		(r_q.bcr == $past(r_q.bcr_sh)))
		else $error("control shadow not updated");

	////////////////////////////////////////////////////////////////////////////
	// Instruction path and path exclusion
	a_shift_ir_lsb: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(fall && r_q.st == ST_SHIFT_IR) |=> (!r_q.oe_n && r_q.tdo == $past(r_q.ir_sh[0])))
		else $error("instruction output not lsb");

	a_shift_ir_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rise && r_q.st == ST_SHIFT_IR) |=>
		(r_q.ir_sh == {$past(tdi), $past(r_q.ir_sh[IR_W-1:1])}))
		else $error("instruction shift wrong");

	// Shadows may only move in the update states or on entry to reset
	a_shadow_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(r_q.st inside {ST_SHIFT_DR, ST_SHIFT_IR, ST_PAUSE_DR, ST_PAUSE_IR}) |=>
		($stable(r_q.bsr) && $stable(r_q.ir) && $stable(r_q.bcr)))
		else $error("shadow moved outside update");

	a_one_path: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(r_q.st inside {ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
		ST_UPD_DR}) |-> $stable(r_q.ir_sh))
		else $error("instruction path moved in data scan");
endmodule

// ==== sim/bstap_master.sv ====
// Behavioural test-bus master: makes the test clock and drives mode-select and data-in.
// Assumes the system clock of the bench; one test clock spans 20 system clocks.
`timescale 1ns/10ps
module bstap_master (
	// System clock
	input  wire logic clk_i,
	// Test bus
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_n_i
);
	initial begin
		tck_o = 1'b1;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One test clock of 160 ns; clock parks high between calls
	task automatic cyc(input logic t, input logic d, output logic o, output logic e);
		repeat (10) @(posedge clk_i);
		tck_o <= 1'b0;
		tms_o <= t;
		tdi_o <= d;
		repeat (10) @(posedge clk_i);
		// Output settled long before the rise, so read just ahead of it
		o = tdo_i;
		e = tdo_oe_n_i;
		tck_o <= 1'b1;
	endtask
endmodule

// ==== sim/tb_bstap_ctrl.sv ====
// Self-checking bench for the test access port controller.
// Assumes the design package and the bus master model are compiled first.
`timescale 1ns/10ps
module tb_bstap_ctrl;
	import bstap_pkg::*;
	logic              clk_i = 0, resetn_i = 0, so_ready_i = 0;
	logic              tck, tms, tdi, tdo_o, tdo_oe_n_o;
	logic              test_logic_reset_o, run_op_o, so_valid_o, so_data_o;
	logic [BSR_W-1:0]  bsr_pins_i = '0, bsr_shadow_o;
	logic [BCR_W-1:0]  bcr_shadow_o;
	logic [IR_W-1:0]   ir_current_o;
	logic [63:0]       r;
	logic              o, e;
	int                fail_count = 0, cmp_count = 0;
	logic              exp_q[$];

	always #4 clk_i = ~clk_i;

	bstap_master m (.clk_i, .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o),
		.tdo_oe_n_i(tdo_oe_n_o));
	bstap_ctrl uut (.clk_i, .resetn_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o,
		.tdo_oe_n_o, .bsr_pins_i, .bsr_shadow_o, .bcr_shadow_o, .ir_current_o,
		.test_logic_reset_o, .run_op_o, .so_valid_o, .so_ready_i, .so_data_o);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [63:0] x, logic [63:0] s);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask

	task automatic chk_bit(logic x, logic s);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("BAD stream exp %b got %b", x, s);
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Drain side stalls at random; the pins never wait on it
	always @(posedge clk_i) so_ready_i <= 1'($urandom_range(0, 1));

	always @(posedge clk_i) begin
		if (resetn_i && so_valid_o === 1'b1 && so_ready_i === 1'b1) begin
			if (exp_q.size() == 0)
				chk("stream_extra", 1, 0);
			else
				chk_bit(exp_q.pop_front(), so_data_o);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scan from Run-Test/Idle back to Run-Test/Idle; 0 < pz < n pauses before bit pz
	task automatic scan(bit ir, int n, logic [63:0] din, logic [63:0] dx, int pz);
		m.cyc(1, 0, o, e);
		if (ir)
			m.cyc(1, 0, o, e);
		m.cyc(0, 0, o, e);
		m.cyc(0, 0, o, e);
		for (int i = 0; i < n; i++) begin
			if (i == pz) begin
				m.cyc(0, 0, o, e);
				chk("oe_pause", 1, e);
				m.cyc(0, 1, o, e);
				m.cyc(1, 0, o, e);
				m.cyc(0, 1, o, e);
			end
			m.cyc(i == n - 1 || i == pz - 1, din[i], o, e);
			chk("tdo", dx[i], o);
			chk("tdo_oe_n", 0, e);
			exp_q.push_back(dx[i]);
		end
		m.cyc(1, 0, o, e);
		chk("oe_exit1", 1, e);
		m.cyc(0, 0, o, e);
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		void'($urandom(84));
		fork
			begin
				#300000;
				fail_count++;
				final_report();
			end
		join_none
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("tlr", 1, test_logic_reset_o);
		chk("ir_rst", 8'h81, ir_current_o);
		chk("bsr_oe", 4'hf, bsr_shadow_o[47:44]);
		chk("bcr_rst", 3'h2, bcr_shadow_o);
		chk("oe_rst", 1, tdo_oe_n_o);
		m.cyc(0, 0, o, e);
		$display("reset values done");

		scan(1, 8, OP_BCR, 8'h81, 99);
		chk("ir_cur", OP_BCR, ir_current_o);
		chk("run_op", 1, run_op_o);
		r = $urandom;
		scan(0, 3, r, 3'h2, 99);
		chk("bcr_upd", r[2:0], bcr_shadow_o);
		$display("control register done");

		scan(1, 8, OP_BYPASS, 8'h81, 99);
		chk("run_idle", 0, run_op_o);
		r = $urandom;
		scan(0, 16, r, {r[14:0], 1'b0}, 5);
		$display("bypass with pause done");

		scan(1, 8, OP_SAMPLE, 8'h81, 3);
		bsr_pins_i <= 48'({$urandom, $urandom});
		r = {$urandom, $urandom};
		repeat (2) @(posedge clk_i);
		scan(0, 48, r, 64'(bsr_pins_i), 99);
		chk("bsr_upd", r[47:0], bsr_shadow_o);
		$display("boundary sample done");

		m.cyc(1, 0, o, e);
		m.cyc(1, 0, o, e);
		m.cyc(0, 0, o, e);
		m.cyc(0, 0, o, e);
		exp_q.push_back(1'b1);
		repeat (5) m.cyc(1, 0, o, e);
		// The last rise reaches the state a few clocks after the pin
		repeat (8) @(posedge clk_i);
		chk("tlr5", 1, test_logic_reset_o);
		chk("ir_tlr", 8'h81, ir_current_o);
		chk("bsr_tlr", 4'hf, bsr_shadow_o[47:44]);
		m.cyc(0, 0, o, e);
		scan(0, 32, 0, 64'(IDCODE_VAL), 99);
		$display("mode-select reset done");

		repeat (100) @(posedge clk_i);
		chk("stream_left", 0, exp_q.size());
		final_report();
	end
endmodule
